//--- hdl/sbl_buf2.sv
/*
  Two-entry buffer with valid/ready on both sides.
  Assumes the consumer may stall indefinitely; nothing is dropped.
*/
`timescale 1ns/1ns
module sbl_buf2 #(
  parameter int W = 9
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [W-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  logic [W-1:0] slot [0:1];
  logic pop, push;

  assign pop = outValid && outReady;
  assign push = inValid && inReady;
  assign outData = slot[0];

  always_ff @(posedge mclk)
    if (rst)
    begin
      slot[0] <= '0;
      slot[1] <= '0;
      outValid <= 1'b0;
      inReady <= 1'b1;
    end
    else if (pop)
    begin
      if (!inReady)
      begin
        slot[0] <= slot[1];
        inReady <= 1'b1;
      end
      else
      begin
        slot[0] <= inData;
        outValid <= push;
      end
    end
    else if (push)
    begin
      if (outValid)
      begin
        slot[1] <= inData;
        inReady <= 1'b0;
      end
      else
      begin
        slot[0] <= inData;
        outValid <= 1'b1;
      end
    end

  a_full_holds: assert property (@(posedge mclk) disable iff (rst)
    !inReady |-> outValid)
    else $error("full buffer shows no output");
  a_stall_stable: assert property (@(posedge mclk) disable iff (rst)
    (outValid && !outReady) |=> (outValid && $stable(outData)))
    else $error("stalled word changed");
endmodule // sbl_buf2

//--- hdl/sbl_char_rx.sv
/*
  Character receiver: start/stop framing, optional parity, held character.
  Assumes the line pin is asynchronous to mclk and bitDiv is at least 4.
*/
`timescale 1ns/1ns
module sbl_char_rx (
  input wire logic mclk,
  input wire logic rst,
  input wire logic rxdPin,
  input wire logic [15:0] bitDiv,
  input wire logic dataBits8,
  input wire logic parEn,
  input wire logic parOdd,
  input wire logic take,
  output logic [7:0] charData,
  output logic charValid,
  output logic parityErr,
  output logic framingErr,
  output logic overrunErr
);
  import sbl_pkg::*;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} sbl_rx_state_type;
  sbl_rx_state_type rxState;
  logic rxdMeta, rxdSync, rxdPrev;
  logic [15:0] tick;
  logic [3:0] bitIdx;
  logic [3:0] lastIdx;
  logic [8:0] shiftIn;
  logic [7:0] dataWord;
  logic parBit, finish;

  assign lastIdx = (dataBits8 ? 4'h7 : 4'h6) + {3'h0, parEn};
  assign dataWord = dataBits8 ? shiftIn[7:0] : {1'b0, shiftIn[6:0]};
  assign parBit = dataBits8 ? shiftIn[8] : shiftIn[7];
  assign finish = (rxState == RX_STOP) && (tick == 16'h0000);

  always_ff @(posedge mclk)
    if (rst)
    begin
      rxdMeta <= 1'b1;
      rxdSync <= 1'b1;
      rxdPrev <= 1'b1;
    end
    else
    begin
      rxdMeta <= rxdPin;
      rxdSync <= rxdMeta;
      rxdPrev <= rxdSync;
    end

  always_ff @(posedge mclk)
    if (rst)
    begin
      rxState <= RX_IDLE;
      tick <= 16'h0000;
      bitIdx <= 4'h0;
      shiftIn <= 9'h000;
    end
    else
    begin
      if (tick != 16'h0000)
        tick <= tick - 16'h0001;
      unique case (rxState)
        RX_IDLE:
          if (rxdPrev && !rxdSync)
          begin
            rxState <= RX_START;
            tick <= bitDiv >> 1;
          end
        RX_START:
          if (tick == 16'h0000)
          begin
            // A glitch shorter than half a bit is not a start
            rxState <= (rxdSync == START_BIT) ? RX_BITS : RX_IDLE;
            tick <= bitDiv - 16'h0001;
            bitIdx <= 4'h0;
          end
        RX_BITS:
          if (tick == 16'h0000)
          begin
            shiftIn[bitIdx] <= rxdSync;
            bitIdx <= bitIdx + 4'h1;
            tick <= bitDiv - 16'h0001;
            if (bitIdx == lastIdx)
              rxState <= RX_STOP;
          end
        RX_STOP:
          if (tick == 16'h0000)
            rxState <= RX_IDLE;
      endcase
    end

  always_ff @(posedge mclk)
    if (rst)
    begin
      charData <= 8'h00;
      charValid <= 1'b0;
      parityErr <= 1'b0;
      framingErr <= 1'b0;
      overrunErr <= 1'b0;
    end
    else
    begin
      parityErr <= finish && parEn && ((^dataWord ^ parBit) != parOdd);
      framingErr <= finish && (rxdSync != STOP_BIT);
      overrunErr <= finish && charValid && !take;
      if (finish)
      begin
        charData <= dataWord;
        charValid <= 1'b1;
      end
      else if (take)
        charValid <= 1'b0;
    end

  a_stop_check: assert property (@(posedge mclk) disable iff (rst)
    finish |=> (framingErr == !$past(rxdSync)))
    else $error("framing flag disagrees with stop sample");
  a_overrun_flag: assert property (@(posedge mclk) disable iff (rst)
    (finish && charValid && !take) |=> (overrunErr && charValid))
    else $error("overrun not flagged");
  a_start_timer: assert property (@(posedge mclk) disable iff (rst)
    (rxState == RX_IDLE && rxdPrev && !rxdSync) |=> (rxState == RX_START))
    else $error("start edge missed");
endmodule // sbl_char_rx

//--- hdl/sbl_link_framer.sv
/*
  Block link framer: enquiry/acknowledge handshake, header and data blocks
  with a longitudinal check byte, character framing and error lights.
  Assumes a 20 MHz clock, config held stable while busy, one peer on the line.
*/
`timescale 1ns/1ns
module sbl_link_framer #(
  parameter int TIMEOUT_CYC = sbl_pkg::ACK_TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire sbl_pkg::sbl_cfg_type cfg,
  input wire logic rxd,
  output logic txd,
  input wire logic startXfer,
  output logic busy,
  output logic xferDone,
  input wire logic [7:0] txByte,
  input wire logic txValid,
  input wire logic txLast,
  output logic txReady,
  output logic [7:0] rxByte,
  output logic rxIsHeader,
  output logic rxValid,
  input wire logic rxReady,
  output sbl_pkg::sbl_err_type err,
  input wire logic clearLeds,
  output logic ledOverrun,
  output logic ledFraming,
  output logic ledTimeout
);
  import sbl_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE, SRC_ENQ, SRC_WENQ, SRC_SOH, SRC_HDR, SRC_ETB, SRC_HLRC, SRC_WHDR,
    SRC_STX, SRC_DAT, SRC_ETX, SRC_DLRC, SRC_WDAT, SRC_EOT,
    TGT_ACK, TGT_WAIT, TGT_HDR, TGT_DAT, TGT_LRC
  } sbl_state_type;
  sbl_state_type state;

  logic parEn, parOdd;
  logic [7:0] charData;
  logic charValid, charTake, got, payloadChar;
  logic rxParErr, rxFrmErr, rxOvrErr;
  logic bufInReady;
  logic [8:0] bufOut;
  logic [7:0] txLrc, rxLrc;
  logic blockBad, hdrBlock;
  logic [31:0] waitCnt;
  logic waiting, timedOut;
  logic txLoad, payLoad, txIdle, pBit;
  logic [7:0] txLoadByte, dWord;
  logic [10:0] frame;
  logic [3:0] frameLen;
  logic [10:0] txShift;
  logic [3:0] txLeft;
  logic [15:0] txTick;

  // Even parity is not legal in native mode; it falls back to odd
  assign parEn = cfg.parity != PAR_NONE;
  assign parOdd = (cfg.parity == PAR_ODD) || !cfg.remoteTerminalMode;

  sbl_char_rx uRx (
    .mclk(mclk),
    .rst(rst),
    .rxdPin(rxd),
    .bitDiv(cfg.bitDiv),
    .dataBits8(cfg.dataBits8),
    .parEn(parEn),
    .parOdd(parOdd),
    .take(charTake),
    .charData(charData),
    .charValid(charValid),
    .parityErr(rxParErr),
    .framingErr(rxFrmErr),
    .overrunErr(rxOvrErr)
  );

  // Binary data holding an end code ends the block early: no byte count here
  assign payloadChar = ((state == TGT_HDR) && (charData != CH_ETB))
    || ((state == TGT_DAT) && (charData != CH_ETX) && (charData != CH_ETB));
  // A full buffer leaves the character held, so the next one overruns
  assign charTake = payloadChar ? bufInReady : 1'b1;
  assign got = charValid && charTake;

  sbl_buf2 #(.W(9)) uBuf (
    .mclk(mclk),
    .rst(rst),
    .inData({hdrBlock, charData}),
    .inValid(charValid && payloadChar),
    .inReady(bufInReady),
    .outData(bufOut),
    .outValid(rxValid),
    .outReady(rxReady)
  );
  assign rxByte = bufOut[7:0];
  assign rxIsHeader = bufOut[8];

  assign waiting = (state == SRC_WENQ) || (state == SRC_WHDR)
    || (state == SRC_WDAT) || (state == TGT_WAIT);
  assign timedOut = waiting && (waitCnt == 32'(TIMEOUT_CYC - 1));

  always_ff @(posedge mclk)
    if (rst || !waiting || got)
      waitCnt <= 32'h0000_0000;
    else
      waitCnt <= waitCnt + 32'h0000_0001;

  // Transmit byte selection
  assign txIdle = txLeft == 4'h0;
  assign payLoad = txReady && txValid;
  always_comb
  begin
    txLoad = txIdle;
    txLoadByte = CH_ACK;
    unique case (state)
      SRC_ENQ: txLoadByte = CH_ENQ;
      SRC_SOH: txLoadByte = CH_SOH;
      SRC_ETB: txLoadByte = CH_ETB;
      SRC_STX: txLoadByte = CH_STX;
      SRC_ETX: txLoadByte = CH_ETX;
      SRC_HLRC, SRC_DLRC: txLoadByte = txLrc;
      SRC_EOT: txLoadByte = CH_EOT;
      TGT_ACK: txLoadByte = CH_ACK;
      SRC_HDR, SRC_DAT:
      begin
        txLoad = payLoad;
        txLoadByte = txByte;
      end
      default: txLoad = 1'b0;
    endcase
  end

  assign dWord = cfg.dataBits8 ? txLoadByte : {1'b0, txLoadByte[6:0]};
  assign pBit = (^dWord) ^ parOdd;
  always_comb
  begin
    if (cfg.dataBits8)
      frame = parEn ? {1'b1, pBit, dWord, START_BIT} : {2'b11, dWord, START_BIT};
    else
      frame = parEn ? {2'b11, pBit, dWord[6:0], START_BIT}
        : {3'b111, dWord[6:0], START_BIT};
  end
  assign frameLen = (cfg.dataBits8 ? 4'ha : 4'h9) + {3'h0, parEn};

  always_ff @(posedge mclk)
    if (rst)
    begin
      txShift <= 11'h7ff;
      txLeft <= 4'h0;
      txTick <= 16'h0000;
      txd <= STOP_BIT;
    end
    else if (txLoad)
    begin
      txShift <= frame;
      txLeft <= frameLen;
      txTick <= cfg.bitDiv - 16'h0001;
      txd <= START_BIT;
    end
    else if (!txIdle)
    begin
      if (txTick == 16'h0000)
      begin
        txShift <= {1'b1, txShift[10:1]};
        txLeft <= txLeft - 4'h1;
        txTick <= cfg.bitDiv - 16'h0001;
        // Stop bit already spans a full bit time before the next start
        txd <= (txLeft == 4'h1) ? STOP_BIT : txShift[1];
      end
      else
        txTick <= txTick - 16'h0001;
    end

  // Payload handshake: ready is offered for one cycle while the line is idle
  always_ff @(posedge mclk)
    if (rst)
      txReady <= 1'b0;
    else
      txReady <= ((state == SRC_HDR) || (state == SRC_DAT)) && txIdle && txValid
        && !txReady;

  always_ff @(posedge mclk)
    if (rst)
      txLrc <= LRC_RESET;
    else if (txLoad && ((state == SRC_SOH) || (state == SRC_STX)))
      txLrc <= LRC_RESET;
    else if (payLoad && ((state == SRC_HDR) || (state == SRC_DAT)))
      txLrc <= txLrc ^ txByte;

  always_ff @(posedge mclk)
    if (rst)
    begin
      rxLrc <= LRC_RESET;
      blockBad <= 1'b0;
      hdrBlock <= 1'b0;
    end
    else if (got && (state == TGT_WAIT))
    begin
      rxLrc <= LRC_RESET;
      // A damaged opening delimiter already spoils the block
      blockBad <= rxParErr || rxFrmErr || rxOvrErr;
      hdrBlock <= charData == CH_SOH;
    end
    else
    begin
      if (got && payloadChar)
        rxLrc <= rxLrc ^ charData;
      if (rxParErr || rxFrmErr || rxOvrErr)
        blockBad <= 1'b1;
    end

  always_ff @(posedge mclk)
    if (rst)
      state <= ST_IDLE;
    else
      unique case (state)
        ST_IDLE:
          if (startXfer)
            state <= SRC_ENQ;
          else if (got && charData == CH_ENQ)
            state <= TGT_ACK;
        SRC_ENQ: if (txLoad) state <= SRC_WENQ;
        SRC_WENQ:
          if (got && charData == CH_ACK)
            state <= SRC_SOH;
          else if (timedOut)
            state <= ST_IDLE;
        SRC_SOH: if (txLoad) state <= SRC_HDR;
        SRC_HDR: if (payLoad && txLast) state <= SRC_ETB;
        SRC_ETB: if (txLoad) state <= SRC_HLRC;
        SRC_HLRC: if (txLoad) state <= SRC_WHDR;
        SRC_WHDR:
          if (got && charData == CH_ACK)
            state <= SRC_STX;
          else if (timedOut)
            state <= ST_IDLE;
        SRC_STX: if (txLoad) state <= SRC_DAT;
        SRC_DAT: if (payLoad && txLast) state <= SRC_ETX;
        SRC_ETX: if (txLoad) state <= SRC_DLRC;
        SRC_DLRC: if (txLoad) state <= SRC_WDAT;
        SRC_WDAT:
          if (got && charData == CH_ACK)
            state <= SRC_EOT;
          else if (timedOut)
            state <= ST_IDLE;
        SRC_EOT: if (txLoad) state <= ST_IDLE;
        TGT_ACK: if (txLoad) state <= TGT_WAIT;
        TGT_WAIT:
          if (got)
          begin
            if (charData == CH_SOH)
              state <= TGT_HDR;
            else if (charData == CH_STX)
              state <= TGT_DAT;
            else if (charData == CH_EOT)
              state <= ST_IDLE;
            else if (charData == CH_ENQ)
              state <= TGT_ACK;
          end
          else if (timedOut)
            state <= ST_IDLE;
        TGT_HDR, TGT_DAT: if (got && !payloadChar) state <= TGT_LRC;
        TGT_LRC:
          if (got)
            state <= (charData == rxLrc && !blockBad) ? TGT_ACK : TGT_WAIT;
      endcase

  always_ff @(posedge mclk)
    if (rst)
    begin
      err <= ERR_NONE;
      busy <= 1'b0;
      xferDone <= 1'b0;
    end
    else
    begin
      err.parity <= rxParErr;
      err.framing <= rxFrmErr;
      err.overrun <= rxOvrErr;
      err.block <= (state == TGT_LRC) && got
        && (charData != rxLrc || blockBad);
      err.timeout <= timedOut && (state != TGT_WAIT);
      busy <= state != ST_IDLE;
      xferDone <= ((state == SRC_EOT) && txLoad)
        || ((state == TGT_WAIT) && got && (charData == CH_EOT));
    end

  // Lights stay lit until cleared; a new error beats a clear
  always_ff @(posedge mclk)
    if (rst)
    begin
      ledOverrun <= 1'b0;
      ledFraming <= 1'b0;
      ledTimeout <= 1'b0;
    end
    else
    begin
      ledOverrun <= err.overrun || (ledOverrun && !clearLeds);
      ledFraming <= err.framing || (ledFraming && !clearLeds);
      ledTimeout <= err.timeout || (ledTimeout && !clearLeds);
    end

  a_start_low: assert property (@(posedge mclk) disable iff (rst)
    txLoad |=> (txd == START_BIT))
    else $error("frame did not open with start bit");
  a_idle_high: assert property (@(posedge mclk) disable iff (rst)
    (txIdle && !$past(txLoad)) |-> (txd == STOP_BIT))
    else $error("line not high while idle");
  a_ack_valid: assert property (@(posedge mclk) disable iff (rst)
    (state == TGT_LRC && got && charData == rxLrc && !blockBad) |=>
      (state == TGT_ACK))
    else $error("good block not acknowledged");
  a_bad_noack: assert property (@(posedge mclk) disable iff (rst)
    (state == TGT_LRC && got && charData != rxLrc) |=>
      (err.block && state == TGT_WAIT))
    else $error("bad check byte accepted");
  a_lrc_clear: assert property (@(posedge mclk) disable iff (rst)
    (state == SRC_SOH && txLoad) |=> (txLrc == LRC_RESET))
    else $error("check byte not cleared");
  a_timeout_abort: assert property (@(posedge mclk) disable iff (rst)
    (timedOut && state == SRC_WENQ) |=> (err.timeout && state == ST_IDLE)
      ##1 ledTimeout)
    else $error("time-out not reported");
  a_overrun_led: assert property (@(posedge mclk) disable iff (rst)
    err.overrun |=> ledOverrun)
    else $error("overrun light not set");

  c_source_done: cover property (@(posedge mclk) disable iff (rst)
    state == SRC_EOT && txLoad);
  c_target_ack: cover property (@(posedge mclk) disable iff (rst)
    state == TGT_LRC ##1 state == TGT_ACK);
  c_buffer_full: cover property (@(posedge mclk) disable iff (rst)
    !bufInReady && charValid && payloadChar);
endmodule // sbl_link_framer

//--- hdl/sbl_pkg.sv
/*
  Shared constants and types of the serial block link framer.
  Assumes a single 20 MHz module clock.
*/
package sbl_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int ACK_TIMEOUT_MS = 2;
  localparam int ACK_TIMEOUT_CYC = CLK_HZ / 1000 * ACK_TIMEOUT_MS;
  localparam logic [7:0] CH_SOH = 8'h01;
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_EOT = 8'h04;
  localparam logic [7:0] CH_ENQ = 8'h05;
  localparam logic [7:0] CH_ACK = 8'h06;
  localparam logic [7:0] CH_ETB = 8'h17;
  localparam logic START_BIT = 1'b0;
  localparam logic STOP_BIT = 1'b1;
  localparam logic [7:0] LRC_RESET = 8'h00;

  typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} sbl_parity_type;

  typedef struct packed {
    logic remoteTerminalMode;
    sbl_parity_type parity;
    logic dataBits8;
    logic [15:0] bitDiv;
  } sbl_cfg_type;

  typedef struct packed {
    logic parity;
    logic framing;
    logic overrun;
    logic block;
    logic timeout;
  } sbl_err_type;

  localparam sbl_err_type ERR_NONE = '0;
endpackage

//--- tb/sbl_peer.sv
/*
  Peer on the serial line: checks each frame from the framer, answers
  enquiries and good blocks with acknowledge, sends characters on request.
  Assumes its cfg matches the framer's and bitDiv is even.
*/
`timescale 1ns/1ns
module sbl_peer (
  input wire logic mclk,
  input wire sbl_pkg::sbl_cfg_type cfg,
  input wire logic lineIn,
  output logic lineOut,
  input wire logic answer,
  input wire logic [7:0] gap
);
  import sbl_pkg::*;
  logic [7:0] got[$];
  int bad = 0;
  logic [7:0] acc = LRC_RESET;
  logic inBlk = 1'b0;
  logic lrcNext = 1'b0;
  initial lineOut = STOP_BIT;
  function automatic logic parBit(input logic [7:0] c);
    c &= cfg.dataBits8 ? 8'hff : 8'h7f;
    return (cfg.remoteTerminalMode && cfg.parity == PAR_EVEN) ? ^c : ~^c;
  endfunction
  task automatic bitOut(input logic v);
    lineOut <= v;
    repeat (cfg.bitDiv) @(posedge mclk);
  endtask
  // Faults only when the bench asks for them
  task automatic sendChar(input logic [7:0] c, input bit badPar, input bit badStop);
    int i;
    @(posedge mclk);
    bitOut(START_BIT);
    for (i = 0; i < (cfg.dataBits8 ? 8 : 7); i++)
      bitOut(c[i]);
    if (cfg.parity != PAR_NONE)
      bitOut(parBit(c) ^ badPar);
    bitOut(badStop ? START_BIT : STOP_BIT);
    bitOut(STOP_BIT);
  endtask
  task automatic reply();
    repeat (gap) @(posedge mclk);
    sendChar(CH_ACK, 1'b0, 1'b0);
  endtask
  always
  begin : rxLoop
    logic [7:0] c;
    int i;
    @(negedge lineIn);
    repeat (cfg.bitDiv / 2) @(posedge mclk);
    if (lineIn == START_BIT)
    begin
      c = 8'h00;
      for (i = 0; i < (cfg.dataBits8 ? 8 : 7); i++)
      begin
        repeat (cfg.bitDiv) @(posedge mclk);
        c[i] = lineIn;
      end
      if (cfg.parity != PAR_NONE)
      begin
        repeat (cfg.bitDiv) @(posedge mclk);
        if (lineIn !== parBit(c)) bad++;
      end
      repeat (cfg.bitDiv) @(posedge mclk);
      if (lineIn !== STOP_BIT) bad++;
      got.push_back(c);
      // Own send runs apart so the next frame is not missed
      if (answer && (lrcNext ? c == acc : c == CH_ENQ && !inBlk))
        fork
          reply();
        join_none
      if (lrcNext)
        lrcNext = 1'b0;
      else if (c == CH_SOH || c == CH_STX)
      begin
        acc = LRC_RESET;
        inBlk = 1'b1;
      end
      else if (inBlk && (c == CH_ETB || c == CH_ETX))
      begin
        inBlk = 1'b0;
        lrcNext = 1'b1;
      end
      else if (inBlk)
        acc ^= c;
    end
  end
endmodule // sbl_peer

//--- tb/tb_sbl_link_framer.sv
/*
  Self-checking bench of the block link framer: source and target transfers
  under four line settings, then parity, framing, overrun and time-out.
  Assumes the peer model on the line and a 20 MHz clock.
*/
`timescale 1ns/1ns
module tb_sbl_link_framer;
  import sbl_pkg::*;
  localparam int BOUND = 20000;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic rxd, txd, busy, xferDone, txReady, rxIsHeader, rxValid;
  logic ledOverrun, ledFraming, ledTimeout;
  logic startXfer = 1'b0, txValid = 1'b0, txLast = 1'b0, rxReady = 1'b0;
  logic clearLeds = 1'b0, answer = 1'b1, stall = 1'b0;
  logic [7:0] txByte = 8'h00, gap = 8'h00, rxByte, mask;
  sbl_cfg_type cfg = '{1'b0, PAR_ODD, 1'b1, 16'h0008};
  sbl_err_type err;
  sbl_err_type seen = ERR_NONE;
  int failures = 0, checks = 0, doneCnt = 0;
  logic [31:0] rs = 32'h8cf4, rr = 32'h8cf4;
  logic [8:0] exp[$], rxq[$];
  always #25 mclk = ~mclk;
  assign mask = cfg.dataBits8 ? 8'hff : 8'h7f;
  sbl_link_framer #(.TIMEOUT_CYC(200)) sbl_link_framer_i (.mclk(mclk), .rst(rst), .cfg(cfg),
    .rxd(rxd), .txd(txd), .startXfer(startXfer), .busy(busy), .xferDone(xferDone),
    .txByte(txByte), .txValid(txValid), .txLast(txLast), .txReady(txReady), .rxByte(rxByte),
    .rxIsHeader(rxIsHeader), .rxValid(rxValid), .rxReady(rxReady), .err(err),
    .clearLeds(clearLeds), .ledOverrun(ledOverrun), .ledFraming(ledFraming),
    .ledTimeout(ledTimeout));
  sbl_peer sbl_peer_i (.mclk(mclk), .cfg(cfg), .lineIn(txd), .lineOut(rxd), .answer(answer),
    .gap(gap));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  always @(posedge mclk)
  begin
    seen <= seen | err;
    if (xferDone === 1'b1) doneCnt++;
    if (rxValid === 1'b1 && rxReady) rxq.push_back({rxIsHeader, rxByte});
  end
  always @(negedge mclk)
  begin
    rr = xs(rr);
    rxReady <= !stall && rr[0];
  end
  task automatic conclude();
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks++;
    if (got !== want)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic expire(input int i);
    if (i >= BOUND)
    begin
      chk(i, 0);
      conclude();
    end
  endtask
  // what: 0 peer chars, 1 error mask seen, 2 done count, 3 words read
  task automatic waitFor(input int what, input int n);
    int i;
    bit ok;
    for (i = 0; i < BOUND; i++)
    begin
      @(negedge mclk);
      ok = what == 0 ? sbl_peer_i.got.size() >= n : what == 1 ? (seen & n) != 0 :
        what == 2 ? doneCnt >= n : rxq.size() >= n;
      if (ok) break;
    end
    expire(i);
  endtask
  task automatic putByte(input logic [7:0] b, input logic last);
    int i;
    txByte = b;
    txValid = 1'b1;
    txLast = last;
    for (i = 0; i < BOUND; i++)
    begin
      @(negedge mclk);
      if (txReady === 1'b1) break;
    end
    expire(i);
    @(negedge mclk);
  endtask
  task automatic send(input logic [7:0] c);
    sbl_peer_i.sendChar(c, 1'b0, 1'b0);
  endtask
  task automatic source(input int nh, input int nd);
    logic [7:0] b, l;
    int k, d0;
    sbl_peer_i.got.delete();
    exp.delete();
    seen = ERR_NONE;
    d0 = doneCnt;
    l = LRC_RESET;
    exp.push_back(CH_ENQ);
    exp.push_back(CH_SOH);
    startXfer = 1'b1;
    @(negedge mclk);
    startXfer = 1'b0;
    for (k = 0; k < nh + nd; k++)
    begin
      rs = xs(rs);
      // No control codes in payload: the peer would end its block early
      b = rs[7:0] | 8'h20;
      putByte(b, k == nh - 1 || k == nh + nd - 1);
      b &= mask;
      l ^= b;
      exp.push_back(b);
      if (k == nh - 1)
      begin
        exp.push_back(CH_ETB);
        exp.push_back(l);
        exp.push_back(CH_STX);
        l = LRC_RESET;
      end
    end
    txValid = 1'b0;
    exp.push_back(CH_ETX);
    exp.push_back(l);
    exp.push_back(CH_EOT);
    waitFor(2, d0 + 1);
    waitFor(0, exp.size());
    for (k = 0; k < exp.size(); k++)
      chk(sbl_peer_i.got[k], exp[k][7:0]);
    chk({txd, seen}, {STOP_BIT, ERR_NONE});
  endtask
  task automatic target(input int n, input bit corrupt);
    logic [7:0] b, l;
    int k, blk, g, d0;
    sbl_peer_i.got.delete();
    rxq.delete();
    exp.delete();
    seen = ERR_NONE;
    send(CH_ENQ);
    waitFor(0, 1);
    for (blk = 0; blk < 2; blk++)
    begin
      l = LRC_RESET;
      send(blk ? CH_STX : CH_SOH);
      for (k = 0; k < n; k++)
      begin
        rs = xs(rs);
        b = (blk ? rs[7:0] | 8'h20 : 8'h30 | rs[3:0]) & mask;
        l ^= b;
        exp.push_back({blk == 0, b});
        send(b);
      end
      send(blk ? CH_ETX : CH_ETB);
      g = sbl_peer_i.got.size();
      send(l ^ {7'h00, corrupt && blk});
      if (corrupt && blk)
        waitFor(1, 2);
      else
        waitFor(0, g + 1);
    end
    waitFor(3, exp.size());
    if (corrupt) repeat (300) @(negedge mclk);
    for (k = 0; k < exp.size(); k++)
      chk(rxq[k], exp[k]);
    for (k = 0; k < sbl_peer_i.got.size(); k++)
      chk(sbl_peer_i.got[k], CH_ACK);
    chk(sbl_peer_i.got.size(), corrupt ? 2 : 3);
    if (!corrupt)
    begin
      d0 = doneCnt;
      send(CH_EOT);
      waitFor(2, d0 + 1);
      chk(seen, ERR_NONE);
    end
  endtask
  initial
  begin : mainSeq
    int c, k;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    chk({txd, busy, rxValid, ledOverrun, ledFraming, ledTimeout, err}, 11'h400);
    // Last pass asks for even parity in native mode, which must act as odd
    for (c = 0; c < 4; c++)
    begin
      cfg.remoteTerminalMode = c == 2;
      cfg.parity = c == 0 ? PAR_ODD : c == 1 ? PAR_NONE : PAR_EVEN;
      cfg.dataBits8 = c != 1;
      rs = xs(rs);
      // Reply delay kept well inside the time-out window
      gap = {4'h0, rs[11:8]};
      source(3 + c, 2 + c);
      target(2 + c, 1'b0);
      target(2, 1'b1);
    end
    seen = ERR_NONE;
    sbl_peer_i.sendChar(8'h41, 1'b1, 1'b0);
    waitFor(1, 16);
    sbl_peer_i.sendChar(8'h41, 1'b0, 1'b1);
    waitFor(1, 8);
    chk(ledFraming, 1'b1);
    stall = 1'b1;
    sbl_peer_i.got.delete();
    send(CH_ENQ);
    waitFor(0, 1);
    send(CH_STX);
    // Two buffered words and one held before the overwrite
    for (k = 0; k < 6; k++)
      send(8'h41);
    waitFor(1, 4);
    chk(ledOverrun, 1'b1);
    stall = 1'b0;
    // Close the spoilt block so the target falls back to idle
    send(CH_ETX);
    send(8'h00);
    repeat (300) @(negedge mclk);
    chk(sbl_peer_i.got.size(), 1);
    chk(seen.block, 1'b1);
    answer = 1'b0;
    startXfer = 1'b1;
    @(negedge mclk);
    startXfer = 1'b0;
    waitFor(1, 1);
    answer = 1'b1;
    repeat (4) @(negedge mclk);
    chk({busy, ledTimeout}, 2'b01);
    clearLeds = 1'b1;
    @(negedge mclk);
    clearLeds = 1'b0;
    @(negedge mclk);
    chk({ledOverrun, ledFraming, ledTimeout}, 3'b000);
    chk(sbl_peer_i.bad, 0);
    conclude();
  end
endmodule // tb_sbl_link_framer
